// >>> logic/sdp_pin_ctrl.sv
/*
 Serial-data pin function control: selects what drives the serial output
 pin and how the serial input pin is used.
 Assumes all inputs synchronous to clk; the pad applies out_en and keeper.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_pin_ctrl
    import sdp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire sdp_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] reg_addr_rd,
    input wire sdp_out_src_s out_src,
    output logic out_pin,
    output logic out_en,
    output logic keeper_en,
    input wire logic in_pin,
    output logic in_buf_en,
    output logic in_data,
    output logic general_purpose_input
);

    // ==========================================================
    // Configuration registers and the sampled input level
    logic keeper_dis;
    sdp_out_func_e out_func;
    logic gpo_level;
    sdp_in_mode_e in_mode;
    logic gpi_value;

    // Software writes; reserved upper bits are not stored
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            keeper_dis <= SDP_OUT_KEEPER_RESET;
            out_func <= SDP_OUT_PRIMARY;
            gpo_level <= SDP_OUT_GPO_RESET;
        end
        else if (reg_req.wr && reg_req.addr == SDP_OUT_PIN_ADDR)
        begin
            keeper_dis <= reg_req.wdata[SDP_OUT_KEEPER_BIT];
            out_func <= sdp_out_func_e'(reg_req.wdata[SDP_OUT_FUNC_MSB:SDP_OUT_FUNC_LSB]);
            gpo_level <= reg_req.wdata[SDP_OUT_GPO_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            in_mode <= SDP_IN_ENABLED;
        else if (reg_req.wr && reg_req.addr == SDP_IN_PIN_ADDR)
            in_mode <= sdp_in_mode_e'(reg_req.wdata[SDP_IN_MODE_MSB:SDP_IN_MODE_LSB]);
    end

    // ==========================================================
    // Output pin routing, registered so the pad sees a clean level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            out_pin <= 1'h0;
            out_en <= 1'h0;
        end
        else
        begin
            out_en <= 1'h1;
            case (out_func)
                SDP_OUT_OFF:
                begin
                    out_pin <= 1'h0;
                    out_en <= 1'h0;
                end
                SDP_OUT_PRIMARY: out_pin <= out_src.primary_data;
                SDP_OUT_GPO: out_pin <= gpo_level;
                SDP_OUT_CLOCK: out_pin <= out_src.internal_clock_output;
                SDP_OUT_INT_FIRST: out_pin <= out_src.first_interrupt_line;
                SDP_OUT_INT_SECOND: out_pin <= out_src.second_interrupt_line;
                SDP_OUT_SEC_BCLK: out_pin <= out_src.secondary_bclk;
                SDP_OUT_SEC_WCLK: out_pin <= out_src.secondary_wclk;
                default:
                begin
                    out_pin <= 1'h0;
                    out_en <= 1'h0;
                end
            endcase
        end
    end

    // Keeper is active-low in the register, active-high at the pad
    always_ff @(posedge clk)
    begin
        if (reset)
            keeper_en <= ~SDP_OUT_KEEPER_RESET;
        else
            keeper_en <= ~keeper_dis;
    end

    // ==========================================================
    // Input pin handling; reserved mode treated as powered down
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            in_buf_en <= 1'h0;
            in_data <= 1'h0;
            gpi_value <= 1'h0;
        end
        else
        begin
            case (in_mode)
                SDP_IN_ENABLED:
                begin
                    in_buf_en <= 1'h1;
                    in_data <= in_pin;
                    gpi_value <= in_pin;
                end
                SDP_IN_GPI:
                begin
                    in_buf_en <= 1'h1;
                    in_data <= 1'h0;
                    gpi_value <= in_pin;
                end
                SDP_IN_RESERVED:
                begin
                    in_buf_en <= 1'h0;
                    in_data <= 1'h0;
                    gpi_value <= 1'h0;
                end
                default:
                begin
                    in_buf_en <= 1'h0;
                    in_data <= 1'h0;
                    gpi_value <= 1'h0;
                end
            endcase
        end
    end

    // Level only meaningful in general-purpose input mode
    always_ff @(posedge clk)
    begin
        if (reset)
            general_purpose_input <= 1'h0;
        else
            general_purpose_input <= (in_mode == SDP_IN_GPI) ? gpi_value : 1'h0;
    end

    // ==========================================================
    // Readback; reserved bits read zero
    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else
        begin
            reg_rdata <= 8'h00;
            if (reg_addr_rd == SDP_OUT_PIN_ADDR)
            begin
                reg_rdata[SDP_OUT_KEEPER_BIT] <= keeper_dis;
                reg_rdata[SDP_OUT_FUNC_MSB:SDP_OUT_FUNC_LSB] <= out_func;
                reg_rdata[SDP_OUT_GPO_BIT] <= gpo_level;
            end
            else if (reg_addr_rd == SDP_IN_PIN_ADDR)
            begin
                reg_rdata[SDP_IN_MODE_MSB:SDP_IN_MODE_LSB] <= in_mode;
                // Gate on the current mode: gpi_value lags a mode change by one cycle
                reg_rdata[SDP_IN_READ_BIT] <= (in_mode == SDP_IN_ENABLED || in_mode == SDP_IN_GPI)
                    ? gpi_value : 1'h0;
            end
        end
    end

endmodule
`default_nettype wire

// >>> logic/sdp_pkg.sv
/*
 Package for the serial-data pin function control block: register
 offsets, field positions, reset values, function codes and carriers.
 Assumes a register port giving an 8-bit address, write strobe and data.
*/
`default_nettype none
package sdp_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] SDP_OUT_PIN_ADDR = 8'h35;
    localparam logic [7:0] SDP_IN_PIN_ADDR = 8'h36;

    // ==========================================================
    // Output-pin register fields
    localparam int SDP_OUT_KEEPER_BIT = 4;
    localparam int SDP_OUT_FUNC_LSB = 1;
    localparam int SDP_OUT_FUNC_MSB = 3;
    localparam int SDP_OUT_GPO_BIT = 0;
    localparam logic SDP_OUT_KEEPER_RESET = 1'h1;
    localparam logic SDP_OUT_GPO_RESET = 1'h0;

    // ==========================================================
    // Input-pin register fields
    localparam int SDP_IN_MODE_LSB = 1;
    localparam int SDP_IN_MODE_MSB = 2;
    localparam int SDP_IN_READ_BIT = 0;

    // Output-pin function codes
    typedef enum logic [2:0]
    {
        SDP_OUT_OFF = 3'h0,
        SDP_OUT_PRIMARY = 3'h1,
        SDP_OUT_GPO = 3'h2,
        SDP_OUT_CLOCK = 3'h3,
        SDP_OUT_INT_FIRST = 3'h4,
        SDP_OUT_INT_SECOND = 3'h5,
        SDP_OUT_SEC_BCLK = 3'h6,
        SDP_OUT_SEC_WCLK = 3'h7
    } sdp_out_func_e;

    // Input-pin mode codes
    typedef enum logic [1:0]
    {
        SDP_IN_OFF = 2'h0,
        SDP_IN_ENABLED = 2'h1,
        SDP_IN_GPI = 2'h2,
        SDP_IN_RESERVED = 2'h3
    } sdp_in_mode_e;

    // Signals that may be routed to the output pin
    typedef struct packed
    {
        logic primary_data;
        logic internal_clock_output;
        logic first_interrupt_line;
        logic second_interrupt_line;
        logic secondary_bclk;
        logic secondary_wclk;
    } sdp_out_src_s;

    // Register port request
    typedef struct packed
    {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdp_reg_req_s;
endpackage
`default_nettype wire

// >>> verification/sdp_host_model.sv
/* Far-side host model: drives the routed sources and the input pin.
 Assumes the block's clock; values change just after each edge. */
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model
    import sdp_pkg::*;
(
    input wire logic clk,
    output sdp_out_src_s out_src,
    output logic in_pin
);
    logic [3:0] cnt = 4'h0;
    // Free count; each source gets its own pattern so a wrong route shows
    always @(posedge clk)
    begin
        cnt <= cnt + 4'h1;
    end
    assign out_src = {cnt[0], cnt[1], ~cnt[0], cnt[2], ~cnt[1], cnt[3]};
    assign in_pin = cnt[0] ^ cnt[2];
endmodule
`default_nettype wire

// >>> verification/sdp_pin_ctrl_sva.sv
/* Port checker for sdp_pin_ctrl.
 Assumes a bind into sdp_pin_ctrl by port name. */
`timescale 1ns/1ps
`default_nettype none
module sdp_pin_ctrl_sva
    import sdp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire sdp_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] reg_addr_rd,
    input wire logic out_pin,
    input wire logic out_en,
    input wire logic keeper_en,
    input wire logic in_buf_en,
    input wire logic in_data
);
    // ==========================================================
    // Readback and pad views compared only once writes have settled
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_out;
        $past(reg_addr_rd) == SDP_OUT_PIN_ADDR && !$past(reg_req.wr) && !$past(reg_req.wr, 2)
            && !$past(reset);
    endsequence
    property p_rst;
        disable iff (1'b0) reset |=> !out_en && !keeper_en && !in_buf_en;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not off in reset");
    property p_rel; $fell(reset) |=> out_en && in_buf_en && !keeper_en; endproperty
    a_rel: assert property (p_rel) else $error("bad defaults");
    property p_data; in_data |-> in_buf_en; endproperty
    a_data: assert property (p_data) else $error("data with buffer off");
    property p_rd_out; $past(reg_addr_rd) == SDP_OUT_PIN_ADDR |-> reg_rdata[7:5] == 3'h0; endproperty
    a_rd_out: assert property (p_rd_out) else $error("reserved bits set");
    property p_rd_in;
        $past(reg_addr_rd) == SDP_IN_PIN_ADDR |-> reg_rdata[7:3] == 5'h00
            && (reg_rdata[2] ^ reg_rdata[1] || !reg_rdata[0]);
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("bad input readback");
    property p_off; s_out |-> out_en == (reg_rdata[3:1] != 3'h0); endproperty
    a_off: assert property (p_off) else $error("out_en mismatch");
    property p_keep; s_out |-> keeper_en == !reg_rdata[4]; endproperty
    a_keep: assert property (p_keep) else $error("keeper mismatch");
    property p_gpo; s_out ##0 reg_rdata[3:1] == 3'h2 |-> out_pin == reg_rdata[0]; endproperty
    a_gpo: assert property (p_gpo) else $error("gpo level mismatch");
endmodule
`default_nettype wire

// >>> verification/sdp_pin_ctrl_tb.sv
/* Bench for sdp_pin_ctrl: function table, input modes, resets.
 Assumes sdp_host_model drives the sources and the input pin. */
`timescale 1ns/1ps
`default_nettype none
module sdp_pin_ctrl_tb;
    import sdp_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    sdp_reg_req_s reg_req = '0;
    logic [7:0] reg_addr_rd = 8'h00;
    logic [7:0] reg_rdata;
    sdp_out_src_s out_src;
    sdp_out_src_s src_q;
    logic out_pin, out_en, keeper_en, in_pin, in_buf_en, in_data, general_purpose_input;
    logic [1:0] pin_q;
    logic e;
    int n_errors = 0;
    int compares = 0;
    // Rows of write data and readback; the last sets reserved bits
    logic [15:0] rows [10] = '{16'h0000, 16'h0202, 16'h0404, 16'h0505, 16'h0606,
        16'h0808, 16'h0A0A, 16'h0C0C, 16'h0E0E, 16'hF717};
    // ==========================================================
    // Clock, parts and the values each edge sampled
    always #2.5 clk = ~clk;
    sdp_pin_ctrl dut (.*);
    sdp_host_model host (.clk, .out_src, .in_pin);
    always @(posedge clk)
    begin
        src_q <= out_src;
        pin_q <= {pin_q[0], in_pin};
    end
    task automatic chk(string n, logic [7:0] x, logic [7:0] g);
        compares++;
        if (g !== x)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_req = '{1'b1, a, d};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] x, logic [7:0] k);
        @(negedge clk);
        reg_addr_rd = a;
        repeat (2) @(negedge clk);
        chk("readback", x, reg_rdata & k);
    endtask
    task automatic rst();
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        rd(SDP_OUT_PIN_ADDR, 8'h12, 8'hFF);
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence: table, input modes, then a second reset
    initial
    begin
        rst();
        rd(SDP_IN_PIN_ADDR, 8'h02, 8'hFE);
        rd(8'h37, 8'h00, 8'hFF);
        foreach (rows[i])
        begin
            wr(SDP_OUT_PIN_ADDR, rows[i][15:8]);
            rd(SDP_OUT_PIN_ADDR, rows[i][7:0], 8'hFF);
            e = rows[i][3:1] == 3'h2 ? rows[i][0] : src_q[7 - rows[i][3:1]];
            if (rows[i][3:1] == 3'h1)
                e = src_q[5];
            if (rows[i][3:1] == 3'h0)
                e = 1'b0;
            chk("out_pin", 8'(e), 8'(out_pin));
            chk("out_en", 8'(rows[i][3:1] != 3'h0), 8'(out_en));
            chk("keeper_en", 8'(!rows[i][12]), 8'(keeper_en));
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(SDP_IN_PIN_ADDR, {5'h1F, 2'(m), 1'b1});
            rd(SDP_IN_PIN_ADDR, {5'h00, 2'(m), 1'b0}, 8'hFE);
            chk("in_buf_en", 8'(m == 1 || m == 2), 8'(in_buf_en));
            chk("in_data", 8'(m == 1 && pin_q[0]), 8'(in_data));
            chk("gpi", 8'(m == 2 && pin_q[1]), 8'(general_purpose_input));
            chk("read_bit", 8'((m == 1 || m == 2) && pin_q[1]), 8'(reg_rdata[0]));
        end
        rst();
        summarize();
    end
    // Hang guard, far beyond the roughly 90 cycles the run needs
    initial
    begin
        #20000;
        n_errors++;
        summarize();
    end
endmodule
bind sdp_pin_ctrl sdp_pin_ctrl_sva chk_i (.*);
`default_nettype wire
